// ==== peer_board.sv ====
// model of another board sharing the trigger lines and the bus clock line
`timescale 1ns/1ns
`default_nettype none
module peer_board
   import trig_pkg::*;
(
   input wire logic [PIN_W-1:0] trig_out_i,
   input wire logic [PIN_W-1:0] trig_oe_i,
   input wire logic [NUM_TRIG_LINES-1:0] peer_oe_i,
   input wire logic [NUM_TRIG_LINES-1:0] peer_val_i,
   input wire logic clk_run_i,
   output logic [PIN_W-1:0] wire_o,
   output logic clash_o
);
   logic bus_clk = 1'b0;
   logic [PIN_W-1:0] p_oe;
   logic [PIN_W-1:0] p_val;
   // ---------------------------------------------------------------
   // shared 20 MHz timebase, stands low while stopped
   // ---------------------------------------------------------------
   initial begin
      #7;
      forever begin
         #25;
         bus_clk = clk_run_i ? ~bus_clk : 1'b0;
      end
   end
   // peer drives a trigger line only when told, the clock line while running
   assign p_oe = {clk_run_i, peer_oe_i};
   assign p_val = {bus_clk, peer_val_i};
   // wire level: this board if it drives, else the peer, else the pull-down wins
   always_comb begin
      for (int i = 0; i < PIN_W; i++) begin
         wire_o[i] = trig_oe_i[i] ? trig_out_i[i] : (p_oe[i] & p_val[i]);
      end
   end
   // sticky flag for two boards driving one line
   initial clash_o = 1'b0;
   always @(trig_oe_i or p_oe) begin
      if (|(trig_oe_i & p_oe)) clash_o = 1'b1;
   end
endmodule : peer_board
`default_nettype wire

// ==== ref_tick_gen.sv ====
// divider on the backplane reference clock giving a toggle at the compare rate
`timescale 1ns/1ns
`default_nettype none
module ref_tick_gen
   import trig_pkg::*;
(
   input wire logic clk_ref_i,
   input wire logic rst_b_i,
   output logic tick_tgl_o
);
   logic [1:0] rst_sync_q;
   logic [DIV_CNT_W-1:0] cnt_q;
   logic [DIV_CNT_W-1:0] cnt_d;
   logic tgl_q;
   logic tgl_d;
   logic rst_ref_b;

   // ------------------------------------------------------------------
   // reset level brought into the reference domain
   // ------------------------------------------------------------------
   always_ff @(posedge clk_ref_i) begin
      rst_sync_q <= {rst_sync_q[0], rst_b_i};
   end
   assign rst_ref_b = rst_sync_q[1];

   // count reference edges, flip the toggle once per compare period
   always_comb begin
      cnt_d = cnt_q + DIV_CNT_W'(1);
      tgl_d = tgl_q;
      if (cnt_q == DIV_CNT_W'(REF_DIV - 1)) begin
         cnt_d = '0;
         tgl_d = ~tgl_q;
      end
   end

   always_ff @(posedge clk_ref_i) begin
      if (!rst_ref_b) begin
         cnt_q <= '0;
         tgl_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tgl_q <= tgl_d;
      end
   end

   assign tick_tgl_o = tgl_q;

   // the system reset also masks the cycles before the reset copy has settled
   a_ref_div_range: assert property (@(posedge clk_ref_i) disable iff (!rst_b_i || !rst_ref_b)
      cnt_q <= DIV_CNT_W'(REF_DIV - 1))
      else $error("reference divider left its range");
endmodule : ref_tick_gen
`default_nettype wire

// ==== sync_2ff.sv ====
// two flip-flop synchroniser for level signals entering a clock domain
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stab_q;

   // ------------------------------------------------------------------
   // first stage feeds only the second stage
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      meta_q <= async_i;
      stab_q <= meta_q;
   end

   assign sync_o = stab_q;
endmodule : sync_2ff
`default_nettype wire

// ==== trig_pkg.sv ====
// shared constants and types for the trigger bus and timebase routing block
package trig_pkg;

   // ------------------------------------------------------------------
   // bus geometry
   // ------------------------------------------------------------------
   localparam int NUM_TRIG_LINES = 7;       // routable trigger lines 0..6
   localparam int LINE_SEL_W = 3;           // width of a line selector
   localparam int BP_CLOCK_LINE = 7;        // backplane line that carries the bus clock
   localparam int PIN_W = 8;                // trigger pins incl. backplane clock line

   // ------------------------------------------------------------------
   // clock rates and the phase comparator rate
   // ------------------------------------------------------------------
   localparam int TIMEBASE_HZ = 20_000_000; // master timebase
   localparam int REF_CLK_HZ = 10_000_000;  // backplane reference clock
   localparam int CMP_HZ = 1_000_000;       // phase comparator rate
   localparam int REF_DIV = REF_CLK_HZ / CMP_HZ;   // ref edges per compare tick
   localparam int OSC_DIV = TIMEBASE_HZ / CMP_HZ;  // oscillator edges per compare tick
   localparam int DIV_CNT_W = 5;            // counter width for both dividers

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic RST_DRIVE_EN = 1'b0;    // bus clock line not driven after reset

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      TB_INTERNAL = 2'b01,                  // on-board oscillator
      TB_BUS = 2'b10                        // clock received over the bus
   } tb_src_type;

   typedef struct packed {
      logic en;                             // connection active
      logic drive;                          // 1: drive onto line, 0: receive from line
      logic [LINE_SEL_W-1:0] line;          // chosen trigger line
   } route_cfg_type;

   typedef struct packed {
      logic out;                            // level driven onto the pin
      logic oe;                             // high while this board drives the pin
   } pin_drv_type;

endpackage : trig_pkg

// ==== trigger_bus_clock_routing.sv ====
// timebase selection, bus clock drive, trigger line routing and phase comparator
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - seven two-way trigger lines shared with other boards
// - one extra system clock line carries a shared timebase
// - handshake and pattern timing run from a 20 MHz master timebase
// - timebase comes from the on-board source or the bus clock
// - on-board timebase may be driven onto the bus clock line
// - reset selects on-board timebase; software may change it later
// - backplane variant uses trigger line 7 as bus clock line
// - backplane variant locks 20 MHz master to 10 MHz backplane clock
// - 1 MHz phase comparator error drives the loop filter
// - phase comparator runs from reset with no configuration
// - any control signal can connect to any of seven lines
// - each connection either drives the line or receives from it
module trigger_bus_clock_routing
   import trig_pkg::*;
#(
   parameter int NUM_SIG = 4,               // handshake control signals on this board
   parameter bit BACKPLANE = 1'b0           // backplane variant with line 7 clock and PLL
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic clk_ref_i,              // backplane 10 MHz reference
   input wire logic osc_clk_i,              // on-board 20 MHz oscillator pin
   input wire logic tb_sel_bus_i,           // software: take timebase from bus
   input wire logic clk_drive_en_i,         // software: drive on-board timebase to bus
   input wire route_cfg_type [NUM_SIG-1:0] route_cfg_i,
   input wire logic [NUM_SIG-1:0] sig_gen_i,   // control signals generated on board
   input wire logic [PIN_W-1:0] trig_in_i,
   input wire logic clk_line_in_i,          // dedicated bus clock line, cable variant
   output logic [PIN_W-1:0] trig_out_o,
   output logic [PIN_W-1:0] trig_oe_o,
   output logic clk_line_out_o,
   output logic clk_line_oe_o,
   output logic [NUM_SIG-1:0] sig_rx_o,     // control signals received from lines
   output logic tb_o,                       // master timebase to handshake logic
   output logic tb_bus_sel_o,               // status: timebase taken from bus
   output logic pll_up_o,                   // error to loop filter: speed up
   output logic pll_dn_o                    // error to loop filter: slow down
);
   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   if (NUM_SIG < 1 || NUM_SIG > 32) begin : g_bad_sig
      $error("NUM_SIG must be 1..32");
   end

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic [PIN_W-1:0] trig_s;
   logic osc_s;
   logic clk_line_s;
   logic ref_tgl_s;
   logic ref_tgl;

   sync_2ff #(.WIDTH(PIN_W)) u_sync_trig (
      .clk_i(clk_sys_i),
      .async_i(trig_in_i),
      .sync_o(trig_s)
   );

   sync_2ff #(.WIDTH(3)) u_sync_clk (
      .clk_i(clk_sys_i),
      .async_i({osc_clk_i, clk_line_in_i, ref_tgl}),
      .sync_o({osc_s, clk_line_s, ref_tgl_s})
   );

   ref_tick_gen u_ref_tick (
      .clk_ref_i(clk_ref_i),
      .rst_b_i(rst_b_i),
      .tick_tgl_o(ref_tgl)
   );

   // ------------------------------------------------------------------
   // timebase source selection
   // ------------------------------------------------------------------
   tb_src_type tb_sel_q;
   tb_src_type tb_sel_d;
   logic drive_q;
   logic drive_d;
   logic bus_clk_s;

   // backplane boards see the bus clock on trigger line 7
   assign bus_clk_s = BACKPLANE ? trig_s[BP_CLOCK_LINE] : clk_line_s;

   // software selection taken every cycle; reset forces on-board source
   always_comb begin
      tb_sel_d = tb_sel_bus_i ? TB_BUS : TB_INTERNAL;
      drive_d = clk_drive_en_i;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         tb_sel_q <= TB_INTERNAL;
         drive_q <= RST_DRIVE_EN;
      end else begin
         tb_sel_q <= tb_sel_d;
         drive_q <= drive_d;
      end
   end

   // ------------------------------------------------------------------
   // master timebase and bus clock drive
   // ------------------------------------------------------------------
   logic tb_q;
   logic tb_d;
   logic tb_bus_q;
   logic tb_bus_d;
   pin_drv_type clk_drv_q;
   pin_drv_type clk_drv_d;

   always_comb begin
      tb_bus_d = 1'b0;
      tb_d = osc_s;
      clk_drv_d.out = osc_s;
      clk_drv_d.oe = 1'b0;
      case (tb_sel_q)
         TB_INTERNAL: begin
            tb_d = osc_s;
            clk_drv_d.oe = drive_q;
         end
         TB_BUS: begin
            tb_d = bus_clk_s;
            tb_bus_d = 1'b1;
            clk_drv_d.oe = 1'b0;
         end
         default: begin
            tb_d = osc_s;
            clk_drv_d.oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         tb_q <= 1'b0;
         tb_bus_q <= 1'b0;
         clk_drv_q <= '0;
      end else begin
         tb_q <= tb_d;
         tb_bus_q <= tb_bus_d;
         clk_drv_q <= clk_drv_d;
      end
   end

   assign tb_o = tb_q;
   assign tb_bus_sel_o = tb_bus_q;
   // cable boards drive the dedicated line, backplane boards use line 7
   assign clk_line_out_o = BACKPLANE ? 1'b0 : clk_drv_q.out;
   assign clk_line_oe_o = BACKPLANE ? 1'b0 : clk_drv_q.oe;

   // ------------------------------------------------------------------
   // trigger line routing
   // ------------------------------------------------------------------
   pin_drv_type [PIN_W-1:0] line_drv_q;
   pin_drv_type [PIN_W-1:0] line_drv_d;
   logic [NUM_SIG-1:0] rx_q;
   logic [NUM_SIG-1:0] rx_d;

   // per line: lowest numbered driving signal wins the line
   for (genvar l = 0; l < PIN_W; l++) begin : g_line
      always_comb begin
         line_drv_d[l] = '0;
         if (l < NUM_TRIG_LINES) begin
            for (int s = NUM_SIG - 1; s >= 0; s--) begin
               if (route_cfg_i[s].en && route_cfg_i[s].drive &&
                   route_cfg_i[s].line == LINE_SEL_W'(l)) begin
                  line_drv_d[l].out = sig_gen_i[s];
                  line_drv_d[l].oe = 1'b1;
               end
            end
         end else if (BACKPLANE) begin
            line_drv_d[l] = clk_drv_d;
         end
      end
   end

   // received signals take only the line, never the local generator
   always_comb begin
      rx_d = '0;
      for (int s = 0; s < NUM_SIG; s++) begin
         if (route_cfg_i[s].en && !route_cfg_i[s].drive &&
             route_cfg_i[s].line < LINE_SEL_W'(NUM_TRIG_LINES)) begin
            rx_d[s] = trig_s[route_cfg_i[s].line];
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         line_drv_q <= '0;
         rx_q <= '0;
      end else begin
         line_drv_q <= line_drv_d;
         rx_q <= rx_d;
      end
   end

   for (genvar p = 0; p < PIN_W; p++) begin : g_pin
      assign trig_out_o[p] = line_drv_q[p].out;
      assign trig_oe_o[p] = line_drv_q[p].oe;
   end
   assign sig_rx_o = rx_q;

   // ------------------------------------------------------------------
   // phase comparator: reference and oscillator both divided to 1 MHz
   // ------------------------------------------------------------------
   logic ref_prev_q;
   logic ref_tick;
   logic osc_prev_q;
   logic osc_tick;
   logic [DIV_CNT_W-1:0] osc_cnt_q;
   logic [DIV_CNT_W-1:0] osc_cnt_d;
   logic osc_cmp_tick;
   logic up_q;
   logic up_d;
   logic dn_q;
   logic dn_d;

   assign ref_tick = ref_tgl_s ^ ref_prev_q;
   assign osc_tick = osc_s & ~osc_prev_q;
   assign osc_cmp_tick = osc_tick && (osc_cnt_q == DIV_CNT_W'(OSC_DIV - 1));

   // frequency detector: up on reference tick, down on oscillator compare tick
   always_comb begin
      osc_cnt_d = osc_cnt_q;
      if (osc_tick) begin
         osc_cnt_d = osc_cmp_tick ? '0 : osc_cnt_q + DIV_CNT_W'(1);
      end
      up_d = up_q | ref_tick;
      dn_d = dn_q | osc_cmp_tick;
      if (up_d && dn_d) begin
         up_d = 1'b0;
         dn_d = 1'b0;
      end
      if (!BACKPLANE) begin
         up_d = 1'b0;
         dn_d = 1'b0;
      end
   end

   // no enable bit: the comparator starts straight out of reset
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         ref_prev_q <= 1'b0;
         osc_prev_q <= 1'b0;
         osc_cnt_q <= '0;
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else begin
         ref_prev_q <= ref_tgl_s;
         osc_prev_q <= osc_s;
         osc_cnt_q <= osc_cnt_d;
         up_q <= up_d;
         dn_q <= dn_d;
      end
   end

   assign pll_up_o = up_q;
   assign pll_dn_o = dn_q;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   a_reset_internal_src: assert property (@(posedge clk_sys_i)
      $fell(rst_b_i) |=> (tb_sel_q == TB_INTERNAL) && !clk_line_oe_o && !trig_oe_o[BP_CLOCK_LINE])
      else $error("reset did not select on-board timebase");

   a_no_clock_contend: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (tb_sel_q == TB_BUS) |=> !clk_drv_q.oe)
      else $error("bus clock line driven while receiving timebase");

   a_clock_drive_on: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (tb_sel_q == TB_INTERNAL) && drive_q |=> clk_drv_q.oe && (clk_drv_q.out == $past(osc_s)))
      else $error("on-board timebase not driven to bus clock line");

   a_timebase_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (tb_sel_q == TB_BUS) |=> tb_o == $past(bus_clk_s) && tb_bus_sel_o)
      else $error("timebase not following bus clock");

   a_route_drive_line: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      route_cfg_i[0].en && route_cfg_i[0].drive && route_cfg_i[0].line < 3'h7
      |=> trig_oe_o[$past(route_cfg_i[0].line)]
          && trig_out_o[$past(route_cfg_i[0].line)] == $past(sig_gen_i[0]))
      else $error("routed signal not on its trigger line");

   a_route_recv_line: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      route_cfg_i[0].en && !route_cfg_i[0].drive && route_cfg_i[0].line < 3'h7
      |=> sig_rx_o[0] == $past(trig_s[route_cfg_i[0].line]))
      else $error("received signal not taken from its trigger line");

   a_pfd_exclusive: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !(pll_up_o && pll_dn_o))
      else $error("phase comparator raised both error outputs");

   a_pfd_ref_up: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      BACKPLANE && ref_tick && !dn_q && !osc_cmp_tick |=> pll_up_o [*1] ##1 1'b1)
      else $error("reference tick did not raise up error");

   a_line7_clock_only: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      trig_oe_o[BP_CLOCK_LINE] |-> BACKPLANE && $past(tb_sel_q == TB_INTERNAL))
      else $error("line 7 driven outside bus clock use");
endmodule : trigger_bus_clock_routing
`default_nettype wire

// ==== trigger_bus_clock_routing_tb.sv ====
// self-checking bench for timebase selection, clock drive, routing and phase error
`timescale 1ns/1ns
`default_nettype none
module trigger_bus_clock_routing_tb;
   import trig_pkg::*;
   logic clk_sys = 1'b0, clk_ref = 1'b0, osc = 1'b0, rst_b = 1'b0;
   logic sel_bus = 1'b0, drv_en = 1'b0, p_clk = 1'b0, up_seen, dn_seen, ref_run = 1'b1;
   route_cfg_type [3:0] cfg = '0;
   logic [3:0] gen = 4'h0;
   logic [6:0] p_oe = 7'h00, p_val = 7'h00;
   logic [7:0] t_in, t_out, t_oe;
   logic [3:0] sig_rx;
   logic cl_out, cl_oe, tb_o, bus_sel, up, dn, clash;
   logic c_cl_out, c_cl_oe, c_tb, c_up;
   logic [7:0] c_oe;
   int num_errors = 0, compares = 0, both = 0, n;
   // ---------------------------------------------------------------
   // clocks: system 8 ns, reference 15 ns, oscillator 50 ns
   // ---------------------------------------------------------------
   initial forever #4 clk_sys = ~clk_sys;
   initial begin
      #3;
      forever begin
         #7 clk_ref = ref_run; // stands low while the reference is stopped
         #8 clk_ref = 1'b0;
      end
   end
   initial forever #25 osc = ~osc;
   trigger_bus_clock_routing #(.NUM_SIG(4), .BACKPLANE(1'b1)) i_trigger_bus_clock_routing (
      .clk_sys_i(clk_sys), .rst_b_i(rst_b), .clk_ref_i(clk_ref), .osc_clk_i(osc),
      .tb_sel_bus_i(sel_bus), .clk_drive_en_i(drv_en), .route_cfg_i(cfg),
      .sig_gen_i(gen), .trig_in_i(t_in), .clk_line_in_i(1'b0), .trig_out_o(t_out),
      .trig_oe_o(t_oe), .clk_line_out_o(cl_out), .clk_line_oe_o(cl_oe), .sig_rx_o(sig_rx),
      .tb_o(tb_o), .tb_bus_sel_o(bus_sel), .pll_up_o(up), .pll_dn_o(dn));
   peer_board i_peer_board (.trig_out_i(t_out), .trig_oe_i(t_oe), .peer_oe_i(p_oe),
      .peer_val_i(p_val), .clk_run_i(p_clk), .wire_o(t_in), .clash_o(clash));
   // cable variant: dedicated clock line fed from the shared line 7 wire
   trigger_bus_clock_routing #(.NUM_SIG(4), .BACKPLANE(1'b0)) i_trigger_bus_clock_routing_cable (
      .clk_sys_i(clk_sys), .rst_b_i(rst_b), .clk_ref_i(clk_ref), .osc_clk_i(osc),
      .tb_sel_bus_i(sel_bus), .clk_drive_en_i(drv_en), .route_cfg_i(cfg),
      .sig_gen_i(gen), .trig_in_i(t_in), .clk_line_in_i(t_in[7]), .trig_out_o(),
      .trig_oe_o(c_oe), .clk_line_out_o(c_cl_out), .clk_line_oe_o(c_cl_oe), .sig_rx_o(),
      .tb_o(c_tb), .tb_bus_sel_o(), .pll_up_o(c_up), .pll_dn_o());
   // both error outputs high at once is never allowed
   always @(negedge clk_sys) if (rst_b && up === 1'b1 && dn === 1'b1) both++;
   // ---------------------------------------------------------------
   // compare and helper tasks
   // ---------------------------------------------------------------
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: bit got %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: lines got %h expected %h", $time, got, exp);
      end
   endtask : chk_vec
   task automatic chk_rng(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask : chk_rng
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys);
   endtask : cyc
   // signal under count: 0 timebase, 1 line 7, 2 cable timebase, 3 cable clock line
   function automatic logic pick_sig(input int pick);
      case (pick)
         0: return tb_o;
         1: return t_out[7];
         2: return c_tb;
         default: return c_cl_out;
      endcase
   endfunction : pick_sig
   // rising edges over 400 cycles (3.2 us): 64 for a 20 MHz clock
   task automatic count_rise(input int pick, output int cnt);
      logic prev, cur;
      cnt = 0;
      prev = pick_sig(pick);
      repeat (400) begin
         @(negedge clk_sys);
         cur = pick_sig(pick);
         if (cur === 1'b1 && prev === 1'b0) cnt++;
         prev = cur;
      end
   endtask : count_rise
   task automatic complete_run;
      $display("comparisons %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      cyc(8);
      rst_b = 1'b1;
      up_seen = 1'b0;
      // phase error appears with no configuration at all
      for (int i = 0; i < 1000 && up_seen !== 1'b1; i++) begin
         cyc(1);
         up_seen = up;
      end
      chk_bit(up_seen, 1'b1);
      chk_bit(bus_sel, 1'b0);
      chk_bit(t_oe[7], 1'b0);
      chk_bit(cl_oe, 1'b0);
      chk_bit(cl_out, 1'b0);
      chk_bit(c_up, 1'b0);
      // a stalled reference leaves only oscillator ticks: slow-down error
      ref_run = 1'b0;
      dn_seen = 1'b0;
      for (int i = 0; i < 400 && dn_seen !== 1'b1; i++) begin
         cyc(1);
         dn_seen = dn;
      end
      chk_bit(dn_seen, 1'b1);
      ref_run = 1'b1;
      count_rise(1'b0, n);
      chk_rng(n, 62, 66);
      drv_en = 1'b1;
      cyc(3);
      chk_bit(t_oe[7], 1'b1);
      chk_bit(c_cl_oe, 1'b1);
      chk_bit(c_oe[7], 1'b0);
      count_rise(1'b1, n);
      chk_rng(n, 62, 66);
      count_rise(3, n);
      chk_rng(n, 62, 66);
      sel_bus = 1'b1;
      cyc(3);
      chk_bit(bus_sel, 1'b1);
      chk_bit(t_oe[7], 1'b0);
      chk_bit(c_cl_oe, 1'b0);
      p_clk = 1'b1;
      cyc(2);
      count_rise(1'b0, n);
      chk_rng(n, 62, 66);
      count_rise(2, n);
      chk_rng(n, 62, 66);
      p_clk = 1'b0;
      cyc(10);
      count_rise(1'b0, n);
      chk_rng(n, 0, 0);
      sel_bus = 1'b0;
      cyc(3);
      chk_bit(bus_sel, 1'b0);
      chk_bit(t_oe[7], 1'b1);
      count_rise(1'b0, n);
      chk_rng(n, 62, 66);
      drv_en = 1'b0;
      // every signal to every line, driving then receiving
      for (int s = 0; s < 4; s++) begin
         for (int l = 0; l < NUM_TRIG_LINES; l++) begin
            cfg = '0;
            cfg[s] = '{en: 1'b1, drive: 1'b1, line: 3'(l)};
            gen = 4'h0;
            gen[s] = 1'b1;
            cyc(3);
            chk_vec(t_oe, 8'(1 << l));
            chk_bit(t_out[l], 1'b1);
            gen[s] = 1'b0;
            cyc(3);
            chk_bit(t_out[l], 1'b0);
            // gen stays low while the signal is received
            cfg[s].drive = 1'b0;
            cyc(2);
            chk_vec(t_oe, 8'h00);
            p_oe[l] = 1'b1;
            p_val[l] = 1'b1;
            cyc(5);
            chk_bit(sig_rx[s], 1'b1);
            p_val[l] = 1'b0;
            cyc(5);
            chk_bit(sig_rx[s], 1'b0);
            p_oe = 7'h00;
         end
      end
      // two drivers on one line, and a receive from the clock line
      cfg = '0;
      cfg[0] = '{en: 1'b1, drive: 1'b1, line: 3'd2};
      cfg[1] = '{en: 1'b1, drive: 1'b1, line: 3'd2};
      cfg[2] = '{en: 1'b1, drive: 1'b0, line: 3'd7};
      gen = 4'b0010;
      p_clk = 1'b1;
      cyc(8);
      chk_bit(t_out[2], 1'b0);
      chk_bit(sig_rx[2], 1'b0);
      p_clk = 1'b0;
      chk_rng(both, 0, 0);
      chk_bit(clash, 1'b0);
      // second reset in mid-run returns to the on-board timebase
      sel_bus = 1'b1;
      drv_en = 1'b1;
      cyc(3);
      rst_b = 1'b0;
      cyc(8);
      chk_bit(bus_sel, 1'b0);
      chk_vec(t_oe, 8'h00);
      complete_run();
   end
   // watchdog: the sequence needs about 30 us
   initial begin
      #200000;
      num_errors++;
      $display("Error at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule : trigger_bus_clock_routing_tb
`default_nettype wire
